// [design/ipps_endpoint.sv]
// Purpose: Interrupt IN endpoint answering host polls with data, empty packets or NAK.
// Assumes: Token decode and packet serialiser run on clk_sys beside this block.
// Notes:   Data toggle, retry and halt handling live outside this block.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Full-speed requested period is kept between 1 and 255 frames.
// - Low-speed requested period is kept between 10 and 255 frames.
// - High-speed exponent 1..16 gives period two to (exponent-1) microframes.
// - High-speed endpoint moves at most 3072 bytes per microframe.
// - Over 1024 bytes per period means high-bandwidth, several transactions.
// - High-bandwidth endpoint declares an interval exponent of one.
// - A poll with nothing to send is answered with NAK.
// - Data is offered only while an interrupt condition is pending; a packet started from a full buffer keeps sending after intPending drops.
// - A zero-length data packet is a valid completed transfer.
// - Payload limit is 8 low, 64 full, 1024 high speed.
module ipps_endpoint
	import ipps_pkg::*;
#(
	parameter int FIFO_WORDS = FIFO_DEPTH
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire ipps_speed_t speedMode,
	input  wire logic [7:0]  reqInterval,
	input  wire logic [10:0] reqMaxPacket,
	input  wire logic [11:0] bytesPerPeriod,
	output logic [7:0]       declInterval,
	output logic [16:0]      periodUframes,
	output logic [10:0]      maxPacket,
	output logic             highBandwidth,
	output logic [1:0]       transPerUframe,
	output logic             configError,
	input  wire logic [7:0]  userData,
	input  wire logic        userLast,
	input  wire logic        userValid,
	output logic             userReady,
	input  wire logic        userZlp,
	output logic             intPending,
	input  wire logic        pollIn,
	output logic             respNak,
	output logic             respZlp,
	output logic [7:0]       txData,
	output logic             txLast,
	output logic             txValid,
	input  wire logic        txReady
);
	typedef enum logic [1:0] {
		IPPS_IDLE,
		IPPS_SEND
	} ipps_state_t;

	ipps_state_t state;
	ipps_state_t next_state;
	logic [3:0]  msgCount;
	logic [10:0] byteCount;
	logic        zlpPending;
	logic [8:0]  fifoOut;
	logic        fifoValid;
	logic        fifoFull;

	// Both clamps keep the smaller of a request and a limit; the interval one is widened to share it.
	function automatic logic [10:0] lesserOf(input logic [10:0] a, input logic [10:0] b);
		lesserOf = (a > b) ? b : a;
	endfunction

	// ==================================================================
	// Period and size decode
	wire       isHigh   = (speedMode == IPPS_HIGH);
	wire [7:0] minIntv  = (speedMode == IPPS_LOW) ? LS_MIN_INTERVAL : FS_MIN_INTERVAL;
	wire [7:0] maxIntv  = isHigh ? HS_MAX_EXP : MAX_INTERVAL;
	wire [7:0] clampLo  = (reqInterval < minIntv) ? minIntv : reqInterval;
	wire [7:0] clampInt = 8'(lesserOf({3'h0, clampLo}, {3'h0, maxIntv}));
	// A bad interval is still clamped so the host always gets a usable period; configError tells software.
	wire       intvBad  = (reqInterval < minIntv) || (reqInterval > maxIntv);
	wire       hbNeed   = isHigh && (bytesPerPeriod > HB_THRESHOLD);
	// Low and full speed must fit a period's data in one packet, so their ceiling is the packet size.
	// microframe byte ceiling
	wire       tooMuch  = isHigh ? (bytesPerPeriod > HS_UFRAME_BYTES)
	                             : (bytesPerPeriod > {1'b0, speedMaxPkt(speedMode)});
	wire [10:0] pktLimit = speedMaxPkt(speedMode);
	wire [10:0] effMax   = lesserOf(reqMaxPacket, pktLimit);
	wire [4:0]  expShift = 5'(clampInt - HS_MIN_EXP);

	// ==================================================================
	// Message bookkeeping
	wire pushLast = userValid && userReady && userLast;
	wire popByte  = txValid && txReady;
	wire popLast  = popByte && fifoOut[8];
	wire endPkt   = popByte && txLast;
	// A poll is only taken in idle; one that arrives while a packet is going out is ignored.
	wire idlePoll = pollIn && (state == IPPS_IDLE);
	// offer data for a complete message or a full buffer
	wire hasMsg   = (msgCount != MSG_COUNT_RESET) || fifoFull;

	// Full buffer counts as pending so a message longer than the FIFO can still drain.
	assign intPending = hasMsg || zlpPending;

	// ==================================================================
	// Transmit side
	assign txData  = fifoOut[7:0];
	assign txValid = (state == IPPS_SEND) && fifoValid;
	// Packet ends at the message end or at the maximum size.
	assign txLast  = fifoOut[8] || (byteCount == effMax - 11'h001);

	always_comb begin
		next_state = state;
		case (state)
			IPPS_IDLE: begin
				// A zero maximum size leaves the poll unanswered rather than send a packet nobody can take.
				if (idlePoll && hasMsg && effMax != BYTE_COUNT_RESET) begin
					next_state = IPPS_SEND;
				end
			end
			IPPS_SEND: begin
				if (endPkt) begin
					next_state = IPPS_IDLE;
				end
			end
			default: next_state = IPPS_IDLE;
		endcase
	end

	// ==================================================================
	// Registers
	// The packet byte count survives a dry FIFO mid-packet and restarts only in idle or at a packet end.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state     <= IPPS_IDLE;
			byteCount <= BYTE_COUNT_RESET;
		end else begin
			state     <= next_state;
			byteCount <= (endPkt || state == IPPS_IDLE) ? BYTE_COUNT_RESET
			           : byteCount + 11'(popByte);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			msgCount <= MSG_COUNT_RESET;
		end else begin
			msgCount <= msgCount + 4'(pushLast) - 4'(popLast);
		end
	end

	// Two requests before one poll merge into a single empty report; they are not counted.
	// empty packet request, set wins
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			zlpPending <= 1'b0;
		end else if (userZlp) begin
			zlpPending <= 1'b1;
		end else if (respZlp) begin
			zlpPending <= 1'b0;
		end
	end

	// Answers are registered pulses one cycle after the poll.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			respNak <= 1'b0;
			respZlp <= 1'b0;
		end else begin
			respNak <= idlePoll && !intPending;
			respZlp <= idlePoll && !hasMsg && zlpPending;
		end
	end

	// Config outputs are registered so a change of request never glitches the period the host reads.
	// They follow the inputs one cycle late, so software lets them settle before opening the pipe.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			declInterval   <= FS_MIN_INTERVAL;
			periodUframes  <= UFRAMES_PER_FRAME;
			maxPacket      <= FS_MAX_PKT;
			highBandwidth  <= 1'b0;
			transPerUframe <= 2'h1;
			configError    <= 1'b0;
		end else begin
			declInterval   <= hbNeed ? HB_EXP : clampInt;
			periodUframes  <= hbNeed ? 17'h00001
			                : isHigh ? (17'h00001 << expShift)
			                : 17'(clampInt) * UFRAMES_PER_FRAME;
			maxPacket      <= effMax;
			highBandwidth  <= hbNeed;
			transPerUframe <= !hbNeed ? 2'h1
			                : (bytesPerPeriod > 12'h800) ? 2'h3 : 2'h2;
			configError    <= intvBad || tooMuch;
		end
	end

	// ==================================================================
	// Payload buffer
	// The end flag rides beside each byte, so message ends are known without a second queue.
	ipps_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_WORDS)
	) u_fifo (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.inData   ({userLast, userData}),
		.inValid  (userValid),
		.inReady  (userReady),
		.outData  (fifoOut),
		.outValid (fifoValid),
		.outReady (txReady && state == IPPS_SEND),
		.full     (fifoFull)
	);
endmodule
`default_nettype wire

// [design/ipps_fifo.sv]
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Read data comes straight from the storage array.
`timescale 1ns/1ns
`default_nettype none
module ipps_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic                  full
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	wire              push = inValid && inReady;
	wire              pop  = outValid && outReady;

	// ==================================================================
	// Flags
	assign full     = (count == (AW+1)'(DEPTH));
	assign inReady  = !full;
	assign outValid = (count != '0);
	assign outData  = mem[rdPtr];

	// ==================================================================
	// Storage
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// ==================================================================
	// Pointers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// [design/ipps_pkg.sv]
// Purpose: Shared constants and types for the interrupt IN endpoint.
// Assumes: Byte-wide payload path, one interrupt IN endpoint.
// Notes:   Periods are expressed in 125 us microframe units.
package ipps_pkg;

	// ==================================================================
	// Bus speeds
	typedef enum logic [1:0] {
		IPPS_LOW,
		IPPS_FULL,
		IPPS_HIGH
	} ipps_speed_t;

	// ==================================================================
	// Period limits
	localparam logic [7:0]  FS_MIN_INTERVAL   = 8'h01;
	localparam logic [7:0]  LS_MIN_INTERVAL   = 8'h0a;
	localparam logic [7:0]  MAX_INTERVAL      = 8'hff;
	localparam logic [7:0]  HS_MIN_EXP        = 8'h01;
	localparam logic [7:0]  HS_MAX_EXP        = 8'h10;
	localparam logic [7:0]  HB_EXP            = 8'h01;
	localparam int          MICROFRAME_NS     = 125000;
	localparam int          FRAME_NS          = 1000000;
	localparam logic [16:0] UFRAMES_PER_FRAME = 17'(FRAME_NS / MICROFRAME_NS);

	// ==================================================================
	// Payload limits
	localparam logic [10:0] LS_MAX_PKT        = 11'h008;
	localparam logic [10:0] FS_MAX_PKT        = 11'h040;
	localparam logic [10:0] HS_MAX_PKT        = 11'h400;
	localparam logic [11:0] HS_UFRAME_BYTES   = 12'hc00;
	localparam logic [11:0] HB_THRESHOLD      = 12'h400;

	// ==================================================================
	// Reset values and buffering
	localparam logic [3:0]  MSG_COUNT_RESET   = 4'h0;
	localparam logic [10:0] BYTE_COUNT_RESET  = 11'h000;
	localparam int          FIFO_DEPTH        = 8;

	// Payload limit for a speed, also used to clamp the configured size.
	function automatic logic [10:0] speedMaxPkt(input ipps_speed_t speed);
		case (speed)
			IPPS_LOW:  speedMaxPkt = LS_MAX_PKT;
			IPPS_FULL: speedMaxPkt = FS_MAX_PKT;
			default:   speedMaxPkt = HS_MAX_PKT;
		endcase
	endfunction

endpackage

// [sim/ipps_endpoint_assertions.sv]
// Purpose: Port checks for the interrupt IN endpoint.
// Assumes: One clock; config outputs follow their inputs one cycle later.
// Notes:   Config checks skip the first edge after reset, which still shows reset values.
`timescale 1ns/1ns
`default_nettype none
module ipps_endpoint_assertions
	import ipps_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire ipps_speed_t speedMode,
	input wire logic [7:0]  reqInterval,
	input wire logic [11:0] bytesPerPeriod,
	input wire logic [7:0]  declInterval,
	input wire logic [16:0] periodUframes,
	input wire logic        highBandwidth,
	input wire logic        configError,
	input wire logic        pollIn,
	input wire logic        intPending,
	input wire logic        respNak,
	input wire logic        respZlp,
	input wire logic        txValid
);
	// ========
	// Properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	property p_ls; $past(resetn) && $past(speedMode) == IPPS_LOW |-> declInterval >= LS_MIN_INTERVAL; endproperty
	a_ls: assert property (p_ls) else $error("low speed interval too short");
	property p_fs; $past(resetn) && $past(speedMode) == IPPS_FULL |-> declInterval >= FS_MIN_INTERVAL; endproperty
	a_fs: assert property (p_fs) else $error("full speed interval zero");
	property p_hs; $past(resetn) && $past(speedMode) == IPPS_HIGH && $past(reqInterval) inside {[1:16]}
		&& $past(bytesPerPeriod) <= HB_THRESHOLD |-> periodUframes == 17'h1 << ($past(reqInterval) - 8'h1); endproperty
	a_hs: assert property (p_hs) else $error("high speed period wrong");
	property p_hb; $past(resetn) && $past(speedMode) == IPPS_HIGH
		|-> highBandwidth == ($past(bytesPerPeriod) > HB_THRESHOLD); endproperty
	a_hb: assert property (p_hb) else $error("bandwidth class wrong");
	property p_hbExp; highBandwidth |-> declInterval == HB_EXP; endproperty
	a_hbExp: assert property (p_hbExp) else $error("wide endpoint interval not one");
	property p_cap; $past(resetn) && $past(speedMode) == IPPS_HIGH && $past(bytesPerPeriod) > HS_UFRAME_BYTES
		|-> configError; endproperty
	a_cap: assert property (p_cap) else $error("microframe byte cap not flagged");
	property p_nak; pollIn && !intPending && !txValid |=> respNak && !respZlp && !txValid; endproperty
	a_nak: assert property (p_nak) else $error("idle poll not refused");
	property p_zlp; respZlp |-> $past(pollIn) && !respNak && !txValid; endproperty
	a_zlp: assert property (p_zlp) else $error("empty packet out of turn");
endmodule
bind ipps_endpoint ipps_endpoint_assertions u_ipps_endpoint_assertions (.clk_sys, .resetn, .speedMode,
	.reqInterval, .bytesPerPeriod, .declInterval, .periodUframes, .highBandwidth, .configError, .pollIn,
	.intPending, .respNak, .respZlp, .txValid);
`default_nettype wire

// [sim/ipps_endpoint_tb.sv]
// Purpose: Self-checking bench for the interrupt IN endpoint.
// Assumes: Host model shrinks microframes; expectations follow the period and size limits.
// Notes:   Each scenario is its own task and judges its own results.
`timescale 1ns/1ns
`default_nettype none
module ipps_endpoint_tb
	import ipps_pkg::*;
;
	// ========
	// Signals
	ipps_speed_t speedMode = IPPS_FULL;
	logic        clk_sys = 1'b0, resetn = 1'b0, userLast = 1'b0, userValid = 1'b0, userZlp = 1'b0;
	logic        clientReq = 1'b0, slowTake = 1'b0;
	logic [7:0]  reqInterval = 8'h01, userData = 8'h00, declInterval, txData, rxCount;
	logic [10:0] reqMaxPacket = 11'h004, maxPacket;
	logic [11:0] bytesPerPeriod = 12'h004;
	logic [16:0] periodUframes;
	logic [1:0]  transPerUframe;
	logic        highBandwidth, configError, userReady, intPending, pollIn, respNak, respZlp, txLast, txValid;
	logic        txReady, done;
	int          err_count = 0, checks = 0, nakSeen = 0, zlpSeen = 0;
	logic [7:0]  rxBytes[$];
	ipps_endpoint u_ipps_endpoint (.clk_sys, .resetn, .speedMode, .reqInterval, .reqMaxPacket, .bytesPerPeriod,
		.declInterval, .periodUframes, .maxPacket, .highBandwidth, .transPerUframe, .configError, .userData,
		.userLast, .userValid, .userReady, .userZlp, .intPending, .pollIn, .respNak, .respZlp, .txData, .txLast,
		.txValid, .txReady);
	ipps_host_model u_ipps_host_model (.clk_sys, .resetn, .clientReq, .slowTake, .periodUframes, .respNak,
		.respZlp, .txValid, .txLast, .pollIn, .txReady, .done, .rxCount);
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		nakSeen += int'(respNak === 1'b1);
		zlpSeen += int'(respZlp === 1'b1);
		if (txValid === 1'b1 && txReady === 1'b1)
			rxBytes.push_back(txData);
	end
	// ========
	// Tasks
	task automatic cmp(input string what, input logic [16:0] exp, input logic [16:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic waitDone;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (done !== 1'b1 && n < 600);
		if (n >= 600) begin
			err_count++;
			tally_and_finish();
		end
	endtask
	task automatic pushMsg(input int len, input logic last);
		int n;
		for (int i = 0; i < len; i++) begin
			userData <= 8'h10 + 8'(i);
			userLast <= last && i == len - 1;
			userValid <= 1'b1;
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (userReady !== 1'b1 && n < 50);
			if (n >= 50)
				cmp("userReady", 17'h1, 17'h0);
		end
		userValid <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic cfgCase(input ipps_speed_t sp, input logic [7:0] iv, input logic [10:0] mp, input logic [11:0] bp,
		input logic [7:0] eDecl, input logic [16:0] ePer, input logic [10:0] eMax, input logic eHb, input logic eErr);
		speedMode <= sp;
		reqInterval <= iv;
		reqMaxPacket <= mp;
		bytesPerPeriod <= bp;
		repeat (2) @(posedge clk_sys);
		cmp("declInterval", 17'(eDecl), 17'(declInterval));
		cmp("periodUframes", ePer, periodUframes);
		cmp("maxPacket", 17'(eMax), 17'(maxPacket));
		cmp("highBandwidth", 17'(eHb), 17'(highBandwidth));
		cmp("configError", 17'(eErr), 17'(configError));
	endtask
	// ========
	// Scenarios
	task automatic testReset;
		resetn <= 1'b0;
		@(posedge clk_sys);
		cmp("declInterval", 17'h1, 17'(declInterval));
		cmp("periodUframes", 17'h8, periodUframes);
		cmp("maxPacket", 17'h40, 17'(maxPacket));
		cmp("highBandwidth", 17'h0, 17'(highBandwidth));
		cmp("transPerUframe", 17'h1, 17'(transPerUframe));
		cmp("configError", 17'h0, 17'(configError));
		cmp("respNak", 17'h0, 17'(respNak));
		cmp("respZlp", 17'h0, 17'(respZlp));
		cmp("txValid", 17'h0, 17'(txValid));
		cmp("intPending", 17'h0, 17'(intPending));
		cmp("userReady", 17'h1, 17'(userReady));
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		cmp("maxPacket", 17'h4, 17'(maxPacket));
		$display("reset test over");
	endtask
	task automatic testConfig;
		cfgCase(IPPS_LOW, 8'h05, 11'h064, 12'h008, 8'h0a, 17'h50, 11'h008, 1'b0, 1'b1);
		cfgCase(IPPS_LOW, 8'hff, 11'h008, 12'h008, 8'hff, 17'h7f8, 11'h008, 1'b0, 1'b0);
		cfgCase(IPPS_HIGH, 8'h11, 11'h7d0, 12'h400, 8'h10, 17'h8000, 11'h400, 1'b0, 1'b1);
		cfgCase(IPPS_HIGH, 8'h00, 11'h040, 12'h040, 8'h01, 17'h1, 11'h040, 1'b0, 1'b1);
		cfgCase(IPPS_HIGH, 8'h04, 11'h200, 12'h200, 8'h04, 17'h8, 11'h200, 1'b0, 1'b0);
		cmp("transPerUframe", 17'h1, 17'(transPerUframe));
		cfgCase(IPPS_HIGH, 8'h01, 11'h400, 12'h800, 8'h01, 17'h1, 11'h400, 1'b1, 1'b0);
		cmp("transPerUframe", 17'h2, 17'(transPerUframe));
		cfgCase(IPPS_HIGH, 8'h05, 11'h400, 12'h500, 8'h01, 17'h1, 11'h400, 1'b1, 1'b0);
		cfgCase(IPPS_HIGH, 8'h01, 11'h400, 12'hc01, 8'h01, 17'h1, 11'h400, 1'b1, 1'b1);
		cmp("transPerUframe", 17'h3, 17'(transPerUframe));
		cfgCase(IPPS_FULL, 8'hff, 11'h040, 12'h040, 8'hff, 17'h7f8, 11'h040, 1'b0, 1'b0);
		cfgCase(IPPS_FULL, 8'h00, 11'h041, 12'h040, 8'h01, 17'h8, 11'h040, 1'b0, 1'b1);
		cfgCase(IPPS_FULL, 8'h01, 11'h004, 12'h004, 8'h01, 17'h8, 11'h004, 1'b0, 1'b0);
		$display("config test over");
	endtask
	task automatic testPolls;
		int n0;
		n0 = nakSeen;
		clientReq <= 1'b1;
		waitDone();
		cmp("nakCount", 17'(n0 + 1), 17'(nakSeen));
		cmp("rxCount", 17'h0, 17'(rxCount));
		clientReq <= 1'b0;
		rxBytes.delete();
		pushMsg(6, 1'b1);
		repeat (80) @(posedge clk_sys);
		cmp("intPending", 17'h1, 17'(intPending));
		clientReq <= 1'b1;
		slowTake <= 1'b1;
		waitDone();
		cmp("firstPacket", 17'h4, 17'(rxCount));
		waitDone();
		clientReq <= 1'b0;
		cmp("secondPacket", 17'h2, 17'(rxCount));
		cmp("payloadCount", 17'h6, 17'(rxBytes.size()));
		for (int i = 0; i < 6; i++)
			cmp("payload", 17'(8'h10 + 8'(i)), 17'(rxBytes[i]));
		cmp("intPending", 17'h0, 17'(intPending));
		n0 = zlpSeen;
		userZlp <= 1'b1;
		@(posedge clk_sys);
		userZlp <= 1'b0;
		clientReq <= 1'b1;
		waitDone();
		clientReq <= 1'b0;
		cmp("zlpCount", 17'(n0 + 1), 17'(zlpSeen));
		cmp("rxCount", 17'h0, 17'(rxCount));
		$display("poll test over");
	endtask
	task automatic testFull;
		pushMsg(8, 1'b0);
		cmp("userReady", 17'h0, 17'(userReady));
		cmp("intPending", 17'h1, 17'(intPending));
		clientReq <= 1'b1;
		waitDone();
		clientReq <= 1'b0;
		cmp("rxCount", 17'h4, 17'(rxCount));
		cmp("userReady", 17'h1, 17'(userReady));
		$display("buffer test over");
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		testReset();
		testConfig();
		testPolls();
		testFull();
		testReset();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// [sim/ipps_host_model.sv]
// Purpose: Host that polls the endpoint once per granted period.
// Assumes: A microframe is shrunk to UFRAME_CYCLES clocks to keep runs short.
// Notes:   Grants the declared period exactly; bus errors are not modelled.
`timescale 1ns/1ns
`default_nettype none
module ipps_host_model #(
	parameter int UFRAME_CYCLES = 4
) (
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        clientReq,
	input wire logic        slowTake,
	input wire logic [16:0] periodUframes,
	input wire logic        respNak,
	input wire logic        respZlp,
	input wire logic        txValid,
	input wire logic        txLast,
	output logic            pollIn,
	output logic            txReady,
	output logic            done,
	output logic [7:0]      rxCount
);
	// ========
	// Slot timing
	logic [23:0] slotCnt;
	logic        busy;
	wire         slotDue = slotCnt + 24'h1 >= 24'(periodUframes) * 24'(UFRAME_CYCLES);
	wire         start   = slotDue && clientReq && !busy;
	wire         taken   = txValid && txReady;
	wire         finish  = respNak || respZlp || (taken && txLast);
	// A slow host takes a byte only every other clock, so the endpoint must hold its byte.
	assign txReady = !slowTake || slotCnt[0];
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			slotCnt <= 24'h0;
			pollIn  <= 1'b0;
			busy    <= 1'b0;
			done    <= 1'b0;
			rxCount <= 8'h00;
		end else begin
			slotCnt <= slotDue ? 24'h0 : slotCnt + 24'h1;
			pollIn  <= start;
			busy    <= (busy || start) && !finish;
			done    <= finish;
			rxCount <= start ? 8'h00 : rxCount + 8'(taken);
		end
	end
endmodule
`default_nettype wire
